/* verilog/oic_core.sv */
// Octal input core: latch, counters, alarm flags and status pins
`timescale 1ns/1ps
// Overview of operation
// - Latch/chip-select fall captures all eight states
// - Unfiltered channels sampled at 1 MHz
// - 16-bit down-counter, two byte loads, run bit
// - Sinking input: decrement on rising field input
// - Sourcing input: decrement on falling field input
// - Count bytes read zero while running
// - Stopped counter reads back remaining count
// - Counter-mode channel state bit is meaningless
// - Counter halts at zero, no indication
// - Ready low only when both supplies good
// - Monitor comparator drives pin, flag, lamp
// - Alarm pin low on any enabled primary flag
// - Primary mask gates only the pin; secondary mask feeds summary
// - Primary flags sticky, re-set if cause remains
// - Summary bit is OR of unmasked secondary flags
// - Secondary flags cleared only by their read
// - Clear-on-read set: only primary read clears
// - Otherwise any command clears; thermal shutdown only by primary read
// - Filter is saturating up/down counter at 1 MHz
// - Eight selectable filter delays set the ceiling
module oic_core
    import oic_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  field_in,
    input  wire logic        latch_n,
    input  wire logic        cs_n,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        frame_check_err,
    input  wire logic        mon_low_in,
    input  wire logic        field_uv_in,
    input  wire logic        temp_alarm_in,
    input  wire logic        thermal_shdn_in,
    input  wire logic [7:0]  sec_fault_in,
    input  wire logic        va_good,
    input  wire logic        vl_good,
    output logic             alarm_n_out,
    output logic             alarm_n_oe,
    output logic             monitor_ok_n_out,
    output logic             monitor_ok_n_oe,
    output logic             ready_n_out,
    output logic             ready_n_oe,
    output logic             monitor_lamp
);
    typedef struct packed {
        logic [7:0]      input_state;
        logic            latch_n_d;
        logic            cs_n_d;
        logic [15:0]     tick_div;
        logic            tick;
        logic [7:0]      primary;
        logic [7:0]      secondary;
        logic [7:0]      pmask;
        logic [7:0]      smask;
        logic [7:0]      gcfg;
        logic [7:0]      run;
        logic [7:0][7:0] chcfg;
        logic [7:0]      rdata;
        logic            alarm_oe;
        logic            mok_oe;
        logic            ready_oe;
        logic            lamp;
    } oic_core_s;

    oic_core_s        r_reg;
    oic_core_s        r_next;
    logic [7:0]       st_arr;
    logic [7:0][15:0] cnt_arr;
    logic             capture;
    logic             rd_primary;
    logic             rd_secondary;
    logic             cmd_ok;
    logic [2:0]       cnt_ch;
    logic [7:0]       p_clr;
    logic [7:0]       p_set;

    oic_chan_if ch_if [8] ();

    // Per-channel wiring and byte-load strobes
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_chan
            assign ch_if[gi].tick     = r_reg.tick;
            assign ch_if[gi].field_in = field_in[gi];
            assign ch_if[gi].cfg      = r_reg.chcfg[gi];
            assign ch_if[gi].run      = r_reg.run[gi];
            assign ch_if[gi].wdata    = reg_wdata;
            assign ch_if[gi].ld_hi    = reg_wr && reg_addr == A_COUNT_BASE + 5'(2 * gi);
            assign ch_if[gi].ld_lo    = reg_wr && reg_addr == A_COUNT_BASE + 5'(2 * gi + 1);
            assign st_arr[gi]         = ch_if[gi].state;
            assign cnt_arr[gi]        = ch_if[gi].count;

            oic_channel u_chan (
                .mclk (mclk),
                .rst  (rst),
                .ci   (ch_if[gi].chan)
            );
        end
    endgenerate

    // Decoded events of this cycle
    assign capture      = (r_reg.latch_n_d && !latch_n) || (r_reg.cs_n_d && !cs_n);
    assign rd_primary   = reg_rd && reg_addr == A_PRIMARY;
    assign rd_secondary = reg_rd && reg_addr == A_SECONDARY;
    assign cmd_ok       = reg_rd || reg_wr;
    assign cnt_ch       = reg_addr[3:1];

    // Causes that set primary flags; summary and spare bit handled apart
    always_comb begin
        p_set            = 8'h00;
        p_set[P_MON_LOW]  = mon_low_in;
        p_set[P_FIELD_UV] = field_uv_in;
        p_set[P_TEMP]     = temp_alarm_in;
        p_set[P_TSHDN]    = thermal_shdn_in;
        p_set[P_FRAME]    = frame_check_err;
    end

    // Which primary flags this cycle's access clears
    always_comb begin
        p_clr = 8'h00;
        if (rd_primary) begin
            p_clr = 8'hff;
        end else if (!r_reg.gcfg[G_CLR_ON_READ] && cmd_ok) begin
            p_clr          = 8'hff;
            p_clr[P_TSHDN] = 1'b0;
        end
    end

    // Next state of the core
    always_comb begin
        r_next = r_reg;

        // 1 MHz sample tick from the system clock
        if (r_reg.tick_div == 16'(TICK_CYC - 1)) begin
            r_next.tick_div = 16'h0000;
            r_next.tick     = 1'b1;
        end else begin
            r_next.tick_div = r_reg.tick_div + 16'h0001;
            r_next.tick     = 1'b0;
        end

        // All eight states frozen on the same edge
        r_next.latch_n_d = latch_n;
        r_next.cs_n_d    = cs_n;
        if (capture) begin
            r_next.input_state = st_arr;
        end

        // Set after clear, so a cause in the clearing cycle survives
        r_next.secondary = (r_reg.secondary & ~(rd_secondary ? 8'hff : 8'h00))
                           | sec_fault_in;
        r_next.primary   = (r_reg.primary & ~p_clr) | p_set;
        r_next.primary[P_SUMMARY] = |(r_next.secondary & r_next.smask);
        r_next.primary[7] = 1'b0;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                A_PMASK: r_next.pmask = reg_wdata;
                A_SMASK: r_next.smask = reg_wdata;
                A_GCFG:  r_next.gcfg  = reg_wdata;
                A_RUN:   r_next.run   = reg_wdata;
                default: begin
                    if (reg_addr[4:3] == A_CHCFG_BASE[4:3]) begin
                        r_next.chcfg[reg_addr[2:0]] = reg_wdata;
                    end
                end
            endcase
        end
        // Recompute summary with a mask just written
        r_next.primary[P_SUMMARY] = |(r_next.secondary & r_next.smask);

        // Read data holds the value seen before any clearing
        if (reg_rd) begin
            case (reg_addr)
                A_INPUT_STATE: r_next.rdata = r_reg.input_state;
                A_PRIMARY:     r_next.rdata = r_reg.primary;
                A_SECONDARY:   r_next.rdata = r_reg.secondary;
                A_PMASK:       r_next.rdata = r_reg.pmask;
                A_SMASK:       r_next.rdata = r_reg.smask;
                A_GCFG:        r_next.rdata = r_reg.gcfg;
                A_RUN:         r_next.rdata = r_reg.run;
                default: begin
                    if (reg_addr[4] == A_COUNT_BASE[4]) begin
                        // Hides a moving value that could tear between bytes
                        if (r_reg.run[cnt_ch]) begin
                            r_next.rdata = 8'h00;
                        end else if (!reg_addr[0]) begin
                            r_next.rdata = cnt_arr[cnt_ch][15:8];
                        end else begin
                            r_next.rdata = cnt_arr[cnt_ch][7:0];
                        end
                    end else if (reg_addr[4:3] == A_CHCFG_BASE[4:3]) begin
                        r_next.rdata = r_reg.chcfg[reg_addr[2:0]];
                    end else begin
                        r_next.rdata = 8'h00;
                    end
                end
            endcase
        end

        // Status pins; the masks touch only the alarm pin
        r_next.alarm_oe = |(r_next.primary & r_next.pmask);
        r_next.mok_oe   = !mon_low_in;
        r_next.ready_oe = !(va_good && vl_good);
        r_next.lamp     = r_next.gcfg[G_LAMP_AUTO] ? mon_low_in
                                                   : r_next.gcfg[G_LAMP_MAN];
    end

    // State register; power-on flag comes up set
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_reg             <= '0;
            r_reg.latch_n_d   <= 1'b1;
            r_reg.cs_n_d      <= 1'b1;
            r_reg.primary     <= PRIMARY_RST;
            r_reg.secondary   <= SEC_RST;
            r_reg.pmask       <= PMASK_RST;
            r_reg.smask       <= SMASK_RST;
            r_reg.gcfg        <= GCFG_RST;
            r_reg.run         <= RUN_RST;
            r_reg.chcfg       <= {8{CHCFG_RST}};
            r_reg.alarm_oe    <= |(PRIMARY_RST & PMASK_RST);
            r_reg.ready_oe    <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Open-drain pins: low-side for alarm and monitor, high-side ready
    assign reg_rdata        = r_reg.rdata;
    assign alarm_n_out      = 1'b0;
    assign alarm_n_oe       = r_reg.alarm_oe;
    assign monitor_ok_n_out = 1'b0;
    assign monitor_ok_n_oe  = r_reg.mok_oe;
    assign ready_n_out      = 1'b1;
    assign ready_n_oe       = r_reg.ready_oe;
    assign monitor_lamp     = r_reg.lamp;

    a_latch_capture: assert property (@(posedge mclk) disable iff (rst)
        capture |=> r_reg.input_state == $past(st_arr))
        else $error("input state not captured on falling edge");
    a_tick_spacing: assert property (@(posedge mclk) disable iff (rst)
        r_reg.tick |=> !r_reg.tick)
        else $error("sample tick longer than one cycle");
    a_run_reads_zero: assert property (@(posedge mclk) disable iff (rst)
        (reg_rd && reg_addr[4] && r_reg.run[cnt_ch]) |=> reg_rdata == 8'h00)
        else $error("running count byte not read as zero");
    a_ready_supply: assert property (@(posedge mclk) disable iff (rst)
        (va_good && vl_good && !mon_low_in) ##1 (va_good && vl_good) |=> !ready_n_oe)
        else $error("ready not asserted with good supplies");
    a_monitor_paths: assert property (@(posedge mclk) disable iff (rst)
        mon_low_in |=> !monitor_ok_n_oe && r_reg.primary[P_MON_LOW])
        else $error("monitor comparator not routed");
    a_alarm_pin: assert property (@(posedge mclk) disable iff (rst)
        ##1 (alarm_n_oe == |(r_reg.primary & r_reg.pmask)))
        else $error("alarm pin disagrees with enabled flags");
    a_mask_no_clear: assert property (@(posedge mclk) disable iff (rst)
        (reg_wr && reg_addr == A_PMASK && r_reg.gcfg[G_CLR_ON_READ] && r_reg.primary[P_TEMP])
        |=> r_reg.primary[P_TEMP])
        else $error("mask write changed a flag");
    a_sticky_flag: assert property (@(posedge mclk) disable iff (rst)
        (temp_alarm_in ##1 !cmd_ok [*3]) |-> r_reg.primary[P_TEMP] [*2])
        else $error("temperature flag not held");
    a_summary_or: assert property (@(posedge mclk) disable iff (rst)
        ##1 (r_reg.primary[P_SUMMARY] == |(r_reg.secondary & r_reg.smask)))
        else $error("summary bit is not the unmasked OR");
    a_sec_read_clear: assert property (@(posedge mclk) disable iff (rst)
        rd_secondary |=> r_reg.secondary == $past(sec_fault_in))
        else $error("secondary read did not clear");
    a_read_only_clear: assert property (@(posedge mclk) disable iff (rst)
        (r_reg.gcfg[G_CLR_ON_READ] && !rd_primary && r_reg.primary[P_FRAME])
        |=> r_reg.primary[P_FRAME])
        else $error("flag cleared by other than primary read");
    a_cmd_clear: assert property (@(posedge mclk) disable iff (rst)
        (!r_reg.gcfg[G_CLR_ON_READ] && reg_wr && !frame_check_err)
        |=> !r_reg.primary[P_FRAME] && ($past(r_reg.primary[P_TSHDN]) -> r_reg.primary[P_TSHDN]))
        else $error("command clear wrong");
    a_reset_stopped: assert property (@(posedge mclk)
        $fell(rst) |-> r_reg.run == RUN_RST)
        else $error("counters running after reset");
endmodule

/* pkg/oic_pkg.sv */
// Shared constants for the octal input, counter and alarm core
package oic_pkg;
    // Register map, 5-bit address
    localparam int          ADDR_W         = 5;
    localparam logic [4:0]  A_INPUT_STATE  = 5'h00;
    localparam logic [4:0]  A_PRIMARY      = 5'h01;
    localparam logic [4:0]  A_SECONDARY    = 5'h02;
    localparam logic [4:0]  A_PMASK        = 5'h03;
    localparam logic [4:0]  A_SMASK        = 5'h04;
    localparam logic [4:0]  A_GCFG         = 5'h05;
    localparam logic [4:0]  A_RUN          = 5'h06;
    localparam logic [4:0]  A_CHCFG_BASE   = 5'h08;
    localparam logic [4:0]  A_COUNT_BASE   = 5'h10;

    // Primary alarm flag positions
    localparam int P_MON_LOW  = 0;
    localparam int P_FIELD_UV = 1;
    localparam int P_TEMP     = 2;
    localparam int P_TSHDN    = 3;
    localparam int P_FRAME    = 4;
    localparam int P_POR      = 5;
    localparam int P_SUMMARY  = 6;

    // Global configuration bit positions
    localparam int G_CLR_ON_READ = 0;
    localparam int G_LAMP_AUTO   = 1;
    localparam int G_LAMP_MAN    = 2;

    // Channel configuration bit positions
    localparam int C_DELAY_LSB = 0;
    localparam int C_SOURCE    = 3;
    localparam int C_FLT_EN    = 7;

    // Reset values
    localparam logic [7:0]  PRIMARY_RST = 8'h20;
    localparam logic [7:0]  SEC_RST     = 8'h00;
    localparam logic [7:0]  PMASK_RST   = 8'h7f;
    localparam logic [7:0]  SMASK_RST   = 8'hff;
    localparam logic [7:0]  GCFG_RST    = 8'h02;
    localparam logic [7:0]  RUN_RST     = 8'h00;
    localparam logic [7:0]  CHCFG_RST   = 8'h00;
    localparam logic [15:0] COUNT_RST   = 16'h0000;

    // Timing: sample timebase derived from the system clock
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SAMPLE_PERIOD_NS = 1000;
    localparam int TICK_CYC_DEF     = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLT_DELAY_US [8] = '{50, 100, 400, 800, 1600, 3200, 12800, 20000};
endpackage

/* pkg/oic_chan_if.sv */
// Signals between the core and one input channel
`timescale 1ns/1ps
interface oic_chan_if;
    logic        tick;
    logic        field_in;
    logic [7:0]  cfg;
    logic        run;
    logic        ld_hi;
    logic        ld_lo;
    logic [7:0]  wdata;
    logic        state;
    logic [15:0] count;

    modport core (output tick, field_in, cfg, run, ld_hi, ld_lo, wdata,
                  input state, count);
    modport chan (input tick, field_in, cfg, run, ld_hi, ld_lo, wdata,
                  output state, count);
endinterface

/* verilog/oic_channel.sv */
// One input channel: sampler, glitch filter and down-counter
`timescale 1ns/1ps
module oic_channel
    import oic_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    oic_chan_if.chan  ci
);
    typedef struct packed {
        logic        samp;
        logic [14:0] filt_cnt;
        logic        filt_out;
        logic        prev;
        logic [15:0] count;
    } oic_chan_s;

    oic_chan_s   r_reg;
    oic_chan_s   r_next;
    logic [14:0] limit;
    logic        on_lvl;
    logic        rise;

    // Filter ceiling in sample ticks for the selected delay
    assign limit = 15'(FLT_DELAY_US[ci.cfg[C_DELAY_LSB +: 3]] * 1000 / SAMPLE_PERIOD_NS);
    // Sourcing inputs are on when the pin is low
    assign on_lvl = ci.field_in ^ ci.cfg[C_SOURCE];
    // Bypass gives the raw 1 us sample
    assign ci.state = ci.cfg[C_FLT_EN] ? r_reg.filt_out : r_reg.samp;
    assign ci.count = r_reg.count;
    assign rise     = ci.state & ~r_reg.prev;

    // Sampling, filtering and counting
    always_comb begin
        r_next      = r_reg;
        r_next.prev = ci.state;
        if (ci.tick) begin
            r_next.samp = on_lvl;
            // No-rollover up/down count, output moves only at the ends
            if (r_reg.filt_cnt > limit) begin
                r_next.filt_cnt = limit;
            end else if (r_reg.samp && r_reg.filt_cnt != limit) begin
                r_next.filt_cnt = r_reg.filt_cnt + 15'h0001;
            end else if (!r_reg.samp && r_reg.filt_cnt != 15'h0000) begin
                r_next.filt_cnt = r_reg.filt_cnt - 15'h0001;
            end
            if (r_next.filt_cnt == limit) begin
                r_next.filt_out = 1'b1;
            end else if (r_next.filt_cnt == 15'h0000) begin
                r_next.filt_out = 1'b0;
            end
        end
        // One step per on-going edge, stuck at zero without a flag
        if (ci.run && rise && r_reg.count != 16'h0000) begin
            r_next.count = r_reg.count - 16'h0001;
        end
        if (ci.ld_hi) begin
            r_next.count[15:8] = ci.wdata;
        end
        if (ci.ld_lo) begin
            r_next.count[7:0] = ci.wdata;
        end
    end

    // State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_reg <= '{samp: 1'b0, filt_cnt: 15'h0000, filt_out: 1'b0, prev: 1'b0,
                       count: COUNT_RST};
        end else begin
            r_reg <= r_next;
        end
    end

    a_count_floor: assert property (@(posedge mclk) disable iff (rst)
        (r_reg.count == 16'h0000 && !ci.ld_hi && !ci.ld_lo) |=> r_reg.count == 16'h0000)
        else $error("counter left zero");
    a_count_step: assert property (@(posedge mclk) disable iff (rst)
        (ci.run && rise && r_reg.count != 16'h0000 && !ci.ld_hi && !ci.ld_lo)
        |=> r_reg.count == $past(r_reg.count) - 16'h0001)
        else $error("counter did not step by one");
    a_count_still: assert property (@(posedge mclk) disable iff (rst)
        (!ci.run && !ci.ld_hi && !ci.ld_lo) |=> $stable(r_reg.count))
        else $error("counter moved while stopped");
    a_filter_ends: assert property (@(posedge mclk) disable iff (rst)
        (r_reg.filt_cnt != limit && r_reg.filt_cnt != 15'h0000 && !ci.tick)
        |=> $stable(r_reg.filt_out))
        else $error("filter output moved between limits");
endmodule

/* testbench/oic_host.sv */
// Host model: register commands as the SPI controller hands them over
`timescale 1ns/1ps
module oic_host
    import oic_pkg::*;
(
    input  wire logic       mclk,
    output logic      [4:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    logic [7:0] run_bits = 8'h00;
    // Bus idle with strobes low from time zero
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 15'h0000;
    // One command per call; the bus is scrambled once the strobe drops
    task automatic cmd(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, wr, ~wr};
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {~a, ~d, 2'b00};
        @(posedge mclk);
        #1 q = reg_rdata;
    endtask
    // Run bits are write-only from here, so a shadow keeps the others intact
    task automatic set_run(input int ch, input logic on);
        logic [7:0] q;
        run_bits[ch] = on;
        cmd(1'b1, A_RUN, run_bits, q);
    endtask
    // Stop first, always both bytes, start last
    task automatic start_count(input int ch, input logic [15:0] v);
        logic [7:0] q;
        set_run(ch, 1'b0);
        cmd(1'b1, A_COUNT_BASE + 5'(2 * ch), v[15:8], q);
        cmd(1'b1, A_COUNT_BASE + 5'(2 * ch + 1), v[7:0], q);
        set_run(ch, 1'b1);
    endtask
    // Leaving counter mode: state read, stop, then zero both bytes
    task automatic leave_count(input int ch);
        logic [7:0] q;
        cmd(1'b0, A_INPUT_STATE, 8'h00, q);
        set_run(ch, 1'b0);
        cmd(1'b1, A_COUNT_BASE + 5'(2 * ch), 8'h00, q);
        cmd(1'b1, A_COUNT_BASE + 5'(2 * ch + 1), 8'h00, q);
    endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the octal input core
`timescale 1ns/1ps
module tb;
    import oic_pkg::*;
    localparam int TK = 4;
    localparam int FT = FLT_DELAY_US[0] * 1000 / SAMPLE_PERIOD_NS;
    logic        mclk = 1'b0, rst = 1'b1, latch_n = 1'b1, cs_n = 1'b1;
    logic        va_good = 1'b1, vl_good = 1'b1, reg_wr, reg_rd, al_oe, mok_oe, rdy_oe, lamp;
    logic [7:0]  field_in = 8'h00, sec_in = 8'h00, reg_wdata, reg_rdata, q;
    logic [4:0]  cause = 5'h00, reg_addr;
    logic [2:0]  pins;
    logic [15:0] v, e, st [3];
    logic [31:0] seed = 32'hca7d;
    int          n_errors = 0, n_tests = 0;
    always #5 mclk = ~mclk;
    oic_core #(.TICK_CYC(TK)) uut (
        .mclk(mclk), .rst(rst), .field_in(field_in), .latch_n(latch_n), .cs_n(cs_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .frame_check_err(cause[4]), .mon_low_in(cause[0]),
        .field_uv_in(cause[1]), .temp_alarm_in(cause[2]), .thermal_shdn_in(cause[3]),
        .sec_fault_in(sec_in), .va_good(va_good), .vl_good(vl_good),
        .alarm_n_out(pins[2]), .alarm_n_oe(al_oe), .monitor_ok_n_out(pins[1]),
        .monitor_ok_n_oe(mok_oe), .ready_n_out(pins[0]), .ready_n_oe(rdy_oe),
        .monitor_lamp(lamp));
    oic_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // Xorshift keeps the random stream repeatable
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] exp_count(input logic [15:0] s, input int n);
        return (s > 16'(n)) ? s - 16'(n) : 16'h0000;
    endfunction
    task automatic chk(input string name, input logic [7:0] ex, input logic [7:0] g);
        n_tests++;
        if (g !== ex) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, ex, g);
        end
    endtask
    task automatic final_report();
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Falling chip select freezes all channels, then the state is read
    task automatic snap(output logic [7:0] s);
        @(posedge mclk) cs_n <= 1'b0;
        @(posedge mclk) cs_n <= 1'b1;
        host.cmd(1'b0, A_INPUT_STATE, 8'h00, s);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("alarm_por", 8'h01, 8'(al_oe));
        chk("pin_levels", 8'h01, 8'(pins));
        host.cmd(1'b0, A_PRIMARY, 8'h00, q);
        chk("primary_por", PRIMARY_RST, q);
        host.cmd(1'b0, A_COUNT_BASE + 5'h01, 8'h00, q);
        chk("count_reset", 8'h00, q);
        // Channel 3 sourcing: its latched bit reads inverted
        host.cmd(1'b1, A_CHCFG_BASE + 5'h03, 8'h08, q);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            @(posedge mclk) field_in <= seed[7:0];
            repeat (3 * TK) @(posedge mclk);
            if (i[0])
                latch_n <= 1'b0;
            else
                cs_n <= 1'b0;
            @(posedge mclk) latch_n <= 1'b1;
            cs_n <= 1'b1;
            host.cmd(1'b0, A_INPUT_STATE, 8'h00, q);
            chk("input_state", seed[7:0] ^ 8'h08, q);
        end
        // Ch0 sinking floors at zero, ch1 sourcing and ch2 sinking count five edges
        host.cmd(1'b1, A_CHCFG_BASE + 5'h01, 8'h08, q);
        @(posedge mclk) field_in <= 8'h02;
        repeat (3 * TK) @(posedge mclk);
        st = '{16'h0003, {8'h01, seed[7:0]}, {8'hfe, seed[15:8]}};
        for (int c = 0; c < 3; c++)
            host.start_count(c, st[c]);
        host.cmd(1'b0, A_COUNT_BASE + 5'h02, 8'h00, q);
        chk("count_running", 8'h00, q);
        repeat (5) begin
            @(posedge mclk) field_in <= 8'h05;
            repeat (3 * TK) @(posedge mclk);
            @(posedge mclk) field_in <= 8'h02;
            repeat (3 * TK) @(posedge mclk);
        end
        for (int c = 0; c < 3; c++) begin
            host.set_run(c, 1'b0);
            host.cmd(1'b0, A_COUNT_BASE + 5'(2 * c), 8'h00, v[15:8]);
            host.cmd(1'b0, A_COUNT_BASE + 5'(2 * c + 1), 8'h00, v[7:0]);
            e = exp_count(st[c], 5);
            chk("count_high", e[15:8], v[15:8]);
            chk("count_low", e[7:0], v[7:0]);
            host.leave_count(c);
        end
        // Clear only on primary read; random masks gate the pin alone
        host.cmd(1'b1, A_GCFG, 8'h03, q);
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            host.cmd(1'b1, A_PMASK, seed[7:0] | 8'h01, q);
            @(posedge mclk) cause <= 5'(1 << i);
            repeat (3) @(posedge mclk);
            #1 chk("alarm_pin", 8'(seed[i] | (i == 0)), 8'(al_oe));
            chk("monitor_ok", 8'(i != 0), 8'(mok_oe));
            @(posedge mclk) cause <= 5'h00;
            host.cmd(1'b1, A_SMASK, 8'hff, q);
            host.cmd(1'b0, A_PRIMARY, 8'h00, q);
            chk("primary_sticky", 8'(1 << i), q);
            host.cmd(1'b0, A_PRIMARY, 8'h00, q);
            chk("primary_clear", 8'h00, q);
        end
        // Any command clears, shutdown only a primary read; summary tracks the secondary flags
        host.cmd(1'b1, A_GCFG, 8'h02, q);
        @(posedge mclk) {cause, sec_in} <= {5'h0c, 8'h81};
        @(posedge mclk) {cause, sec_in} <= 13'h0000;
        host.cmd(1'b1, A_SMASK, 8'hff, q);
        host.cmd(1'b0, A_PRIMARY, 8'h00, q);
        chk("primary_cmd", 8'h48, q);
        host.cmd(1'b0, A_SECONDARY, 8'h00, q);
        chk("secondary", 8'h81, q);
        host.cmd(1'b0, A_PRIMARY, 8'h00, q);
        chk("primary_fall", 8'h00, q);
        // Ready from both supplies; the monitor input must not matter
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk) {cause[0], va_good, vl_good} <= 3'(i);
            repeat (2) @(posedge mclk);
            #1 chk("ready_n", (i % 4 == 3) ? 8'h00 : 8'h01, 8'(rdy_oe));
            chk("monitor_lamp", 8'(i > 3), 8'(lamp));
        end
        // Lamp off in manual mode although the monitor input is low
        host.cmd(1'b1, A_GCFG, 8'h00, q);
        chk("lamp_manual", 8'h00, 8'(lamp));
        // Ch4 filtered: a step shows only once the ceiling is reached
        host.cmd(1'b1, A_CHCFG_BASE + 5'h04, 8'h80, q);
        repeat ((FT + 10) * TK) @(posedge mclk);
        field_in <= 8'h12;
        repeat ((FT - 10) * TK) @(posedge mclk);
        snap(q);
        chk("filter_hold", 8'h00, 8'(q[4]));
        repeat (20 * TK) @(posedge mclk);
        snap(q);
        chk("filter_pass", 8'h01, 8'(q[4]));
        final_report();
    end
    // Watchdog well beyond the expected thousand or so cycles
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
endmodule
